/* File: scdt_pkg.sv */
// Constants for the stack setup and reset queue drain timer register bank.
// Assumes a 40 MHz core clock and a 32-bit register bus.
package scdt_pkg;
  localparam int SCDT_ADDR_W = 8;
  localparam int SCDT_DATA_W = 32;
  localparam int SCDT_STACKS = 4;
  localparam int SCDT_CFG_W = 5;
  localparam int SCDT_CFG_STRAP_LO_W = 2;
  localparam int SCDT_DRAIN_W = 16;
  localparam logic [7:0] SCDT_OFF_STACK_ZERO = 8'h10;
  localparam logic [7:0] SCDT_OFF_STACK_ONE = 8'h14;
  localparam logic [7:0] SCDT_OFF_STACK_TWO = 8'h18;
  localparam logic [7:0] SCDT_OFF_STACK_THREE = 8'h1C;
  localparam logic [7:0] SCDT_OFF_DRAIN_TIME = 8'h80;
  localparam logic [7:0] SCDT_OFF_DRAIN_STATUS = 8'h90;
  localparam logic [7:0] SCDT_CFG_OFF [SCDT_STACKS] = '{
    SCDT_OFF_STACK_ZERO, SCDT_OFF_STACK_ONE, SCDT_OFF_STACK_TWO, SCDT_OFF_STACK_THREE};
  localparam logic [4:0] SCDT_CFG_RST = 5'h00;
  localparam logic [2:0] SCDT_CFG_HI_FIXED = 3'h0;
  localparam logic [15:0] SCDT_DRAIN_RST = 16'h00FA;
  localparam int SCDT_DRAIN_BUSY_BIT = 0;
  // Microsecond tick derived from the clock period, rounded up
  localparam int SCDT_US_NS = 1000;
  localparam int SCDT_CLK_NS = 25;
  localparam int SCDT_US_CYCLES = (SCDT_US_NS + SCDT_CLK_NS - 1) / SCDT_CLK_NS;
endpackage

/* File: scdt_drain_timer.sv */
// Microsecond drain interval timer for reset events.
// Assumes the interval input is stable while the timer runs.
`timescale 1ns/1ps
`default_nettype none
module scdt_drain_timer #(
  parameter int unsigned US_CYCLES = scdt_pkg::SCDT_US_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic start_i,
  input wire logic [15:0] time_us_i,
  // Status
  output logic busy_o,
  output logic done_o
);
  typedef enum logic [0:0] {
    SCDT_IDLE = 1'b0,
    SCDT_RUN = 1'b1
  } scdt_state_e;

  scdt_state_e state_reg, state_next;
  logic [15:0] us_left_reg, us_left_next;
  logic [15:0] tick_reg, tick_next;
  logic [15:0] us_total_reg, us_total_next;
  logic done_reg, done_next;

  always_comb begin
    state_next = state_reg;
    us_left_next = us_left_reg;
    tick_next = tick_reg;
    us_total_next = us_total_reg;
    done_next = 1'b0;
    case (state_reg)
      SCDT_IDLE: begin
        if (start_i) begin
          us_total_next = time_us_i;
          if (time_us_i == 16'h0000) begin
            done_next = 1'b1;
          end else begin
            us_left_next = time_us_i;
            tick_next = 16'h0000;
            state_next = SCDT_RUN;
          end
        end
      end
      SCDT_RUN: begin
        if (tick_reg == 16'(US_CYCLES - 1)) begin
          tick_next = 16'h0000;
          if (us_left_reg == 16'h0001) begin
            done_next = 1'b1;
            state_next = SCDT_IDLE;
          end else begin
            us_left_next = us_left_reg - 16'h0001;
          end
        end else begin
          tick_next = tick_reg + 16'h0001;
        end
      end
      default: begin
        state_next = SCDT_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SCDT_IDLE;
      us_left_reg <= 16'h0000;
      tick_reg <= 16'h0000;
      us_total_reg <= 16'h0000;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      us_left_reg <= us_left_next;
      tick_reg <= tick_next;
      us_total_reg <= us_total_next;
      done_reg <= done_next;
    end
  end

  assign busy_o = (state_reg == SCDT_RUN);
  assign done_o = done_reg;

  // Cycles spent running, read only by the checks below
  logic [31:0] run_cycles_reg;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_cycles_reg <= 32'h0000_0000;
    end else if (state_reg == SCDT_RUN) begin
      run_cycles_reg <= run_cycles_reg + 32'h0000_0001;
    end else begin
      run_cycles_reg <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_drain_length;
    done_o && $past(busy_o) |-> ($past(run_cycles_reg) + 32'h1) == 32'(us_total_reg) * 32'(US_CYCLES);
  endproperty
  a_drain_length: assert property (p_drain_length) else $error("drain interval length wrong");

  property p_drain_start;
    start_i && !busy_o && time_us_i != 16'h0000 |=> busy_o [*2];
  endproperty
  a_drain_start: assert property (p_drain_start) else $error("drain did not start");
endmodule
`default_nettype wire

/* File: scdt_regs.sv */
// Stack setup registers and reset queue drain timer, APB slave.
// Assumes rst_n_i is the fundamental reset and straps are steady at its release.
`timescale 1ns/1ps
`default_nettype none
module scdt_regs #(
  parameter int unsigned US_CYCLES = scdt_pkg::SCDT_US_CYCLES
) (
  // Clock and fundamental reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Strap pins
  input wire logic [1:0] stack_zero_strap_i,
  input wire logic [1:0] stack_one_strap_i,
  input wire logic [4:0] stack_two_strap_i,
  input wire logic [4:0] stack_three_strap_i,
  // Reset events that drain queued packets
  input wire logic port_reset_i,
  input wire logic up_sec_bus_reset_i,
  input wire logic down_sec_bus_reset_i,
  input wire logic part_hot_reset_i,
  input wire logic part_fund_reset_i,
  // Stack setup outputs
  output logic [4:0] stack_zero_setup_o,
  output logic [4:0] stack_one_setup_o,
  output logic [4:0] stack_two_setup_o,
  output logic [4:0] stack_three_setup_o,
  // Drain status
  output logic drain_busy_o,
  output logic drain_done_o
);
  logic [4:0] strap_val [scdt_pkg::SCDT_STACKS];
  logic [4:0] setup_reg [scdt_pkg::SCDT_STACKS];
  logic [4:0] setup_next [scdt_pkg::SCDT_STACKS];
  logic loaded_reg, loaded_next;
  logic [15:0] queue_drain_time_reg, queue_drain_time_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic setup_phase, wr_access;
  logic [31:0] rd_val;
  logic rd_hit;
  logic drain_start;

  assign setup_phase = psel_i && !penable_i;
  assign wr_access = psel_i && penable_i && pwrite_i;

  // Stacks zero and one carry only two strap bits
  assign strap_val[0] = {scdt_pkg::SCDT_CFG_HI_FIXED, stack_zero_strap_i};
  assign strap_val[1] = {scdt_pkg::SCDT_CFG_HI_FIXED, stack_one_strap_i};
  assign strap_val[2] = stack_two_strap_i;
  assign strap_val[3] = stack_three_strap_i;

  // Strap capture happens once, at the first edge after fundamental reset
  always_comb begin
    loaded_next = 1'b1;
  end

  generate
    for (genvar g = 0; g < scdt_pkg::SCDT_STACKS; g++) begin : g_stack
      always_comb begin
        setup_next[g] = setup_reg[g];
        if (!loaded_reg) begin
          setup_next[g] = strap_val[g];
        end else if (wr_access && paddr_i == scdt_pkg::SCDT_CFG_OFF[g]) begin
          setup_next[g] = pwdata_i[4:0];
        end
      end

      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          setup_reg[g] <= scdt_pkg::SCDT_CFG_RST;
        end else begin
          setup_reg[g] <= setup_next[g];
        end
      end
    end
  endgenerate

  always_comb begin
    queue_drain_time_next = queue_drain_time_reg;
    if (wr_access && paddr_i == scdt_pkg::SCDT_OFF_DRAIN_TIME) begin
      queue_drain_time_next = pwdata_i[15:0];
    end
  end

  // Read mux; reserved bits return zero
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr_i)
      scdt_pkg::SCDT_OFF_STACK_ZERO: rd_val = {27'h0, setup_reg[0]};
      scdt_pkg::SCDT_OFF_STACK_ONE: rd_val = {27'h0, setup_reg[1]};
      scdt_pkg::SCDT_OFF_STACK_TWO: rd_val = {27'h0, setup_reg[2]};
      scdt_pkg::SCDT_OFF_STACK_THREE: rd_val = {27'h0, setup_reg[3]};
      scdt_pkg::SCDT_OFF_DRAIN_TIME: rd_val = {16'h0, queue_drain_time_reg};
      scdt_pkg::SCDT_OFF_DRAIN_STATUS: rd_val = {31'h0, drain_busy_o};
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (setup_phase) begin
      prdata_next = pwrite_i ? 32'h0000_0000 : rd_val;
      pslverr_next = !rd_hit;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loaded_reg <= 1'b0;
      queue_drain_time_reg <= scdt_pkg::SCDT_DRAIN_RST;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      loaded_reg <= loaded_next;
      queue_drain_time_reg <= queue_drain_time_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready_o = psel_i && penable_i;
  assign prdata_o = prdata_reg;
  assign pslverr_o = pslverr_reg && psel_i && penable_i;

  assign stack_zero_setup_o = setup_reg[0];
  assign stack_one_setup_o = setup_reg[1];
  assign stack_two_setup_o = setup_reg[2];
  assign stack_three_setup_o = setup_reg[3];

  // Any listed reset event opens a drain interval if the timer is idle; events while it is busy are ignored
  assign drain_start = port_reset_i || up_sec_bus_reset_i || down_sec_bus_reset_i ||
    part_hot_reset_i || part_fund_reset_i;

  scdt_drain_timer #(
    .US_CYCLES(US_CYCLES)
  ) u_drain (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .start_i(drain_start),
    .time_us_i(queue_drain_time_reg),
    .busy_o(drain_busy_o),
    .done_o(drain_done_o)
  );

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_apb_write(logic [7:0] off);
    psel_i && !penable_i && pwrite_i && paddr_i == off ##1 psel_i && penable_i;
  endsequence

  property p_setup_write;
    s_apb_write(scdt_pkg::SCDT_OFF_STACK_TWO) |=> setup_reg[2] == $past(pwdata_i[4:0]);
  endproperty
  a_setup_write: assert property (p_setup_write) else $error("stack setup write lost");

  property p_strap_low;
    !loaded_reg |=> setup_reg[0][4:2] == 3'h0 && setup_reg[1][4:2] == 3'h0;
  endproperty
  a_strap_low: assert property (p_strap_low) else $error("upper setup bits not zero");

  property p_strap_zero_one;
    !loaded_reg |=> setup_reg[0][1:0] == $past(stack_zero_strap_i) &&
      setup_reg[1][1:0] == $past(stack_one_strap_i);
  endproperty
  a_strap_zero_one: assert property (p_strap_zero_one) else $error("low strap bits");

  property p_strap_two_three;
    !loaded_reg |=> setup_reg[2] == $past(stack_two_strap_i) &&
      setup_reg[3] == $past(stack_three_strap_i);
  endproperty
  a_strap_two_three: assert property (p_strap_two_three) else $error("strap field");

  property p_drain_write;
    s_apb_write(scdt_pkg::SCDT_OFF_DRAIN_TIME) |=> queue_drain_time_reg == $past(pwdata_i[15:0]);
  endproperty
  a_drain_write: assert property (p_drain_write) else $error("drain time write lost");

  property p_drain_default;
    !loaded_reg |-> queue_drain_time_reg == scdt_pkg::SCDT_DRAIN_RST;
  endproperty
  a_drain_default: assert property (p_drain_default) else $error("drain default wrong");

  property p_sample_once;
    loaded_reg && !wr_access |=> loaded_reg && $stable(setup_reg[1]) && $stable(setup_reg[2]) &&
      $stable(setup_reg[3]);
  endproperty
  a_sample_once: assert property (p_sample_once) else $error("straps resampled");

  property p_reserved_zero;
    psel_i && penable_i && !pwrite_i |-> prdata_o[31:16] == 16'h0 &&
      (paddr_i == scdt_pkg::SCDT_OFF_DRAIN_TIME || prdata_o[15:5] == 11'h000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_hold;
    loaded_reg && !wr_access |=> $stable(queue_drain_time_reg) && $stable(setup_reg[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("value changed without write");
endmodule
`default_nettype wire

/* File: scdt_regs_tb_top.sv */
// Self-checking bench for the stack setup and drain timer register bank.
// Assumes scdt_pkg is compiled first; APB is driven directly by the bench.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t mismatch got %h exp %h", $time, (a), (e)); end end
module scdt_regs_tb_top;
  localparam int US = 2;
  // Drain time used for the event scenarios, not below the reset default
  localparam logic [15:0] DRAIN_US = 16'h0100;
  logic mclk_i;
  logic rst_n_i;
  logic psel_i;
  logic penable_i;
  logic pwrite_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [1:0] s0;
  logic [1:0] s1;
  logic [4:0] s2;
  logic [4:0] s3;
  logic [4:0] ev;
  logic [4:0] o0;
  logic [4:0] o1;
  logic [4:0] o2;
  logic [4:0] o3;
  logic drain_busy_o;
  logic drain_done_o;
  int num_errors = 0;
  int comparisons = 0;

  scdt_regs #(.US_CYCLES(US)) scdt_regs_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .stack_zero_strap_i(s0),
    .stack_one_strap_i(s1), .stack_two_strap_i(s2), .stack_three_strap_i(s3),
    .port_reset_i(ev[0]), .up_sec_bus_reset_i(ev[1]), .down_sec_bus_reset_i(ev[2]),
    .part_hot_reset_i(ev[3]), .part_fund_reset_i(ev[4]), .stack_zero_setup_o(o0),
    .stack_one_setup_o(o1), .stack_two_setup_o(o2), .stack_three_setup_o(o3),
    .drain_busy_o(drain_busy_o), .drain_done_o(drain_done_o)
  );

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic conclude();
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (pready_o !== 1'b1) begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
  endtask

  // Reads all five read-write registers and the setup outputs
  task automatic chk_all(input logic [4:0] z, o, t, h, input logic [15:0] dt);
    logic [31:0] r;
    logic e;
    logic [4:0] x [4];
    x = '{z, o, t, h};
    `CHK({o0, o1, o2, o3}, {z, o, t, h})
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, scdt_pkg::SCDT_CFG_OFF[i], 32'h0, r, e);
      `CHK(r, {27'h0, x[i]})
    end
    apb(1'b0, scdt_pkg::SCDT_OFF_DRAIN_TIME, 32'h0, r, e);
    `CHK(r, {16'h0, dt})
  endtask

  // Pulses one reset event and counts busy and done cycles
  task automatic drain_one(input int i);
    int nb;
    int nd;
    nb = 0;
    nd = 0;
    @(posedge mclk_i);
    ev <= 5'h01 << i;
    @(posedge mclk_i);
    ev <= 5'h00;
    repeat (int'(DRAIN_US) * US + 16) begin
      @(posedge mclk_i);
      nb += (drain_busy_o === 1'b1);
      nd += (drain_done_o === 1'b1);
    end
    `CHK(nb, int'(DRAIN_US) * US)
    `CHK(nd, 1)
  endtask

  // Unmapped offset: error response, write ignored, read zero
  task automatic unmapped();
    logic [31:0] r;
    logic e;
    apb(1'b1, 8'h44, 32'hFFFF_FFFF, r, e);
    `CHK(e, 1'b1)
    apb(1'b0, 8'h44, 32'h0, r, e);
    `CHK({e, r}, {1'b1, 32'h0})
  endtask

  // Status bit follows the running interval
  task automatic drain_status();
    logic [31:0] r;
    logic e;
    @(posedge mclk_i);
    ev <= 5'h08;
    @(posedge mclk_i);
    ev <= 5'h00;
    apb(1'b0, scdt_pkg::SCDT_OFF_DRAIN_STATUS, 32'h0, r, e);
    `CHK({e, r}, {1'b0, 32'h0000_0001})
    repeat (int'(DRAIN_US) * US + 16) @(posedge mclk_i);
    apb(1'b0, scdt_pkg::SCDT_OFF_DRAIN_STATUS, 32'h0, r, e);
    `CHK({e, r}, {1'b0, 32'h0000_0000})
  endtask

  initial begin
    logic [31:0] r;
    logic e;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    pwrite_i <= 1'b0;
    paddr_i <= 8'h00;
    pwdata_i <= 32'h0;
    ev <= 5'h00;
    s0 <= 2'h2;
    s1 <= 2'h1;
    s2 <= 5'h15;
    s3 <= 5'h0A;
    do_reset();
    chk_all(5'h02, 5'h01, 5'h15, 5'h0A, 16'h00FA);
    s0 <= 2'h1;
    s1 <= 2'h3;
    s2 <= 5'h04;
    s3 <= 5'h1B;
    chk_all(5'h02, 5'h01, 5'h15, 5'h0A, 16'h00FA);
    // Writes with upper reserved bits set
    apb(1'b1, 8'h10, 32'hFFFF_FFEB, r, e);
    apb(1'b1, 8'h14, 32'hFFFF_FFF6, r, e);
    apb(1'b1, 8'h18, 32'hFFFF_FFFD, r, e);
    apb(1'b1, 8'h1C, 32'hFFFF_FFE7, r, e);
    apb(1'b1, 8'h80, 32'hABCD_1234, r, e);
    chk_all(5'h0B, 5'h16, 5'h1D, 5'h07, 16'h1234);
    unmapped();
    apb(1'b1, 8'h80, {16'h0, DRAIN_US}, r, e);
    for (int i = 0; i < 5; i++) begin
      drain_one(i);
    end
    drain_status();
    chk_all(5'h0B, 5'h16, 5'h1D, 5'h07, DRAIN_US);
    do_reset();
    chk_all(5'h01, 5'h03, 5'h04, 5'h1B, 16'h00FA);
    conclude();
  end
endmodule
`default_nettype wire
